// >>> bench/loop_serial_status_registers_test.sv
// self-checking bench for the loop serial status register bank
module loop_serial_status_registers_test;
  timeunit 1ns;
  timeprecision 1ns;
  import loop_status_pkg::*;
  localparam logic [17:0] PULSE = 18'h3_C0AA;
  localparam logic [31:0] NOSRQ = 32'hBFFF_FFFF;
  logic core_clk, rst, start, slow, statusRequest, byteAccept, statusValid, statusLast;
  logic serviceRequest, done, keyM, brkM, synM, swM;
  logic [3:0] reqEn, stk;
  logic [7:0] condEn, statusData, sysB, b2, b3, b4;
  logic [31:0] answer;
  logic [2:0] count;
  logic [17:0] tbl [7];
  cond_t cnd;
  int err_total, n_tests, cycles;
  loop_serial_status_registers i_dut (.core_clk(core_clk), .rst(rst), .cond(cnd),
    .requestEnableControl(reqEn), .conditionEnable(condEn), .statusRequest(statusRequest),
    .byteAccept(byteAccept), .statusData(statusData), .statusValid(statusValid),
    .statusLast(statusLast), .serviceRequest(serviceRequest), .systemConditionByte(sysB),
    .bufferLineErrorByte(b2), .handshakeEventByte(b3), .spareStatusByte(b4));
  status_poller i_poller (.core_clk(core_clk), .rst(rst), .start(start), .slow(slow),
    .statusData(statusData), .statusValid(statusValid), .statusLast(statusLast),
    .statusRequest(statusRequest), .byteAccept(byteAccept), .answer(answer), .count(count),
    .done(done));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // --------------------------------
  // reference model
  // --------------------------------
  function automatic logic [31:0] expect_bytes();
    logic [7:0] b;
    if (cnd.autoDisc) b = 8'h85;
    else if (keyM) b = 8'h89;
    else if (brkM) b = 8'h8A;
    else if (stk != 4'h0) b = 8'h83;
    else if (cnd.rxNotEmpty) b = 8'hA2;
    else if (cnd.txNotFull) b = 8'hA1;
    else b = 8'hA3;
    return {b, stk, cnd.rxFull, cnd.rxNotEmpty, cnd.txNotFull, cnd.txEmpty,
      !cnd.rtsOut && cnd.ctsIn, keyM, cnd.autoDisc, brkM, cnd.remoteMode, synM, swM,
      cnd.hwBlock, 8'h00};
  endfunction
  function automatic void apply_model();
    stk |= {cnd.parityErr, cnd.frameErr, cnd.overrun, cnd.rxOverflow};
    keyM |= cnd.keyPress;
    brkM |= cnd.breakRx;
    synM |= cnd.syntaxErr;
    swM = cnd.swRedefine ? 1'b0 : (swM | cnd.swBlock);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // --------------------------------
  // stimulus tasks
  // --------------------------------
  // events last one cycle; live views are compared once they have landed
  task automatic step(input logic [17:0] r);
    @(negedge core_clk);
    cnd = r;
    apply_model();
    @(negedge core_clk);
    // compare before touching cnd, so the live views have settled from this stimulus
    check("live", expect_bytes() & NOSRQ, {sysB & 8'hBF, b2, b3, b4});
    cnd = r & ~PULSE;
    apply_model();
  endtask
  task automatic poll(input logic slw);
    logic [31:0] exp;
    int n;
    @(negedge core_clk);
    exp = expect_bytes();
    slow = slw;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 80) begin
      @(negedge core_clk);
      n++;
    end
    check("done", 32'h1, 32'(done === 1'b1));
    check("answer", exp & NOSRQ, answer & NOSRQ);
    check("count", 32'd4, 32'(count));
    check("cleared", 32'h0, 32'({statusValid, b2[7:4], b3[6], b3[4], b3[2]}));
    {stk, keyM, brkM, synM} = '0;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h88a4));
    {rst, start, slow, reqEn, condEn, cnd, stk, keyM, brkM, synM, swM} = '0;
    rst = 1'b1;
    tbl = '{18'h0_0040, 18'h0_0080, 18'h0_0020, 18'h2_0000, 18'h0_1000, 18'h0_0800, 18'h0};
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    check("reset", 32'h0, 32'({statusValid, serviceRequest, statusData}));
    step(18'h3_FFFF);
    poll(1'b0);
    poll(1'b1);
    for (int k = 0; k < 7; k++) begin
      step(tbl[k]);
      poll(k[0]);
    end
    for (int i = 0; i < 48; i++) begin
      reqEn = 4'($urandom);
      condEn = 8'($urandom);
      step(18'($urandom) & (~PULSE | (18'($urandom) & 18'($urandom))));
      if (i % 4 == 3) poll(i[2]);
    end
    reqEn = 4'h8;
    condEn = 8'h40;
    step(18'h0_0040);
    repeat (3) @(negedge core_clk);
    check("srq set", 32'h1C5, 32'({serviceRequest, sysB}));
    poll(1'b0);
    check("srq byte", 32'hC5, 32'(answer[31:24]));
    step(18'h0);
    repeat (2) @(negedge core_clk);
    check("srq clear", 32'h0, 32'({serviceRequest, sysB[6]}));
    reqEn = 4'h0;
    step(18'h0_0040);
    repeat (3) @(negedge core_clk);
    check("srq off", 32'h0, 32'({serviceRequest, sysB[6]}));
    test_done();
  end
endmodule

// >>> bench/status_poller.sv
// loop controller model that asks for status and takes the answer
module status_poller (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] statusData,
  input wire logic statusValid,
  input wire logic statusLast,
  output logic statusRequest,
  output logic byteAccept,
  output logic [31:0] answer,
  output logic [2:0] count,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  // no new request while an answer is still in flight
  assign statusRequest = start && !busy;
  initial byteAccept = 1'b0;
  // a slow controller stalls at random; each raised accept is taken at the next edge
  always @(negedge core_clk) begin
    byteAccept <= statusValid && (!slow || $urandom_range(1, 0) == 1);
  end
  always @(posedge core_clk) begin
    done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
    end else if (statusRequest) begin
      busy <= 1'b1;
      count <= 3'd0;
    end else if (busy && statusValid && byteAccept) begin
      answer <= {answer[23:0], statusData};
      count <= count + 3'd1;
      busy <= !statusLast;
      done <= statusLast;
    end
  end
endmodule

// >>> verilog/loop_serial_status_registers.sv
// status byte bank of a serial-loop to rs-232 interface
//
// Function
// - four status bytes, refreshed on every change
// - byte one shows highest active condition
// - autodisconnect then key press codes
// - break received code at priority three
// - data error code at priority four
// - receive data waiting code priority five
// - transmit not full, then full codes
// - bit six marks request, clears appropriately
// - device bytes report all bits together
// - parity and frame error bits
// - overrun and buffer overflow bits
// - low bits track buffer state live
// - sticky flags clear after status answer, except the software block flag
// - cts true while rts false bit
// - key, autodisconnect and break bits
// - remote mode and syntax error bits
// - software handshake block, cleared on redefine
// - hardware handshake blocking bit
// - fourth byte reserved, fixed value
// - request needs enable bit and condition
// - request pending marks passing frames
`include "loop_status_map.svh"

module loop_serial_status_registers (
  input wire logic core_clk,
  input wire logic rst,
  input wire loop_status_pkg::cond_t cond,
  input wire logic [3:0] requestEnableControl,
  input wire logic [7:0] conditionEnable,
  input wire logic statusRequest,
  input wire logic byteAccept,
  output logic [7:0] statusData,
  output logic statusValid,
  output logic statusLast,
  output logic serviceRequest,
  output logic [7:0] systemConditionByte,
  output logic [7:0] bufferLineErrorByte,
  output logic [7:0] handshakeEventByte,
  output logic [7:0] spareStatusByte
);
  import loop_status_pkg::*;

  state_t cur_reg;
  state_t cur_next;
  logic [7:0] baseCode;
  logic [6:0] activeVec;
  logic [7:0] b2;
  logic [7:0] b3;
  logic trigger;
  logic sentByte1;
  logic answerDone;

  // ----------------------------------------------------------------
  // priority encoding of the system byte
  // ----------------------------------------------------------------
  always_comb begin
    activeVec = {cond.autoDisc, cur_reg.keySeen, cur_reg.breakSeen,
                 |cur_reg.byte2Sticky, cond.rxNotEmpty, cond.txNotFull,
                 !cond.txNotFull};
    if (cond.autoDisc) begin
      baseCode = `CODE_NO_ROOM;
    end else if (cur_reg.keySeen) begin
      baseCode = `CODE_KEY_INPUT;
    end else if (cur_reg.breakSeen) begin
      baseCode = `CODE_BREAK;
    end else if (|cur_reg.byte2Sticky) begin
      baseCode = `CODE_DATA_ERR;
    end else if (cond.rxNotEmpty) begin
      baseCode = `CODE_RX_READY;
    end else if (cond.txNotFull) begin
      baseCode = `CODE_TX_READY;
    end else begin
      baseCode = `CODE_TX_FULL;
    end
  end

  // conditionEnable bit i (6..0) enables priority level 7-i as a request source
  assign trigger = requestEnableControl[`ENABLE_SRQ_BIT]
                   && |(activeVec & conditionEnable[6:0]);
  assign sentByte1 = cur_reg.dataValid && byteAccept && cur_reg.index == 3'd0;
  assign answerDone = cur_reg.dataValid && byteAccept
                      && cur_reg.index == (`BYTE_COUNT - 3'd1);

  // ----------------------------------------------------------------
  // device status bytes, all bits visible together
  // ----------------------------------------------------------------
  always_comb begin
    b2 = {cur_reg.byte2Sticky, cond.rxFull, cond.rxNotEmpty,
          cond.txNotFull, cond.txEmpty};
    b3 = {!cond.rtsOut && cond.ctsIn, cur_reg.keySeen, cond.autoDisc,
          cur_reg.breakSeen, cond.remoteMode, cur_reg.syntaxSeen,
          cur_reg.swBlockFlag, cond.hwBlock};
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    // sticky flags: an event in the clearing cycle survives the clear
    if (answerDone) begin
      cur_next.byte2Sticky = 4'h0;
      cur_next.keySeen = 1'b0;
      cur_next.breakSeen = 1'b0;
      cur_next.syntaxSeen = 1'b0;
    end
    cur_next.byte2Sticky = cur_next.byte2Sticky | {cond.parityErr, cond.frameErr,
                           cond.overrun, cond.rxOverflow};
    if (cond.keyPress) begin
      cur_next.keySeen = 1'b1;
    end
    if (cond.breakRx) begin
      cur_next.breakSeen = 1'b1;
    end
    if (cond.syntaxErr) begin
      cur_next.syntaxSeen = 1'b1;
    end
    if (cond.swRedefine) begin
      cur_next.swBlockFlag = 1'b0;
    end else if (cond.swBlock) begin
      cur_next.swBlockFlag = 1'b1;
    end
    // request flag follows its cause, drops after byte one is sent
    cur_next.prevCode = baseCode;
    if (!trigger || sentByte1) begin
      cur_next.srqFlag = 1'b0;
    end else if (baseCode != cur_reg.prevCode || !cur_reg.srqFlag
                 && cur_reg.state == IDLE && !statusRequest) begin
      cur_next.srqFlag = 1'b1;
    end
    case (cur_reg.state)
      IDLE: begin
        cur_next.dataValid = 1'b0;
        if (statusRequest) begin
          cur_next.state = SEND;
          cur_next.index = 3'd0;
          cur_next.dataValid = 1'b1;
          cur_next.dataOut = {baseCode[7], cur_reg.srqFlag, baseCode[5:0]};
        end
      end
      SEND: begin
        if (byteAccept) begin
          cur_next.index = cur_reg.index + 3'd1;
          case (cur_reg.index)
            3'd0: cur_next.dataOut = b2;
            3'd1: cur_next.dataOut = b3;
            3'd2: cur_next.dataOut = `SPARE_VALUE;
            default: cur_next.dataOut = 8'h00;
          endcase
          if (answerDone) begin
            cur_next.state = IDLE;
            cur_next.dataValid = 1'b0;
            cur_next.index = 3'd0;
          end
        end
      end
      default: begin
        cur_next.state = IDLE;
        cur_next.dataValid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_reg <= '{state: IDLE, index: 3'd0, dataOut: 8'h00, dataValid: 1'b0,
                   srqFlag: 1'b0, prevCode: 8'h00, byte2Sticky: 4'h0,
                   keySeen: 1'b0, breakSeen: 1'b0, syntaxSeen: 1'b0,
                   swBlockFlag: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  // live views refresh every cycle from current conditions
  assign systemConditionByte = {baseCode[7], cur_reg.srqFlag, baseCode[5:0]};
  assign bufferLineErrorByte = b2;
  assign handshakeEventByte = b3;
  assign spareStatusByte = `SPARE_VALUE;
  assign statusData = cur_reg.dataOut;
  assign statusValid = cur_reg.dataValid;
  assign statusLast = cur_reg.dataValid && cur_reg.index == (`BYTE_COUNT - 3'd1);
  // loop side marks passing data, end and identify frames while high
  assign serviceRequest = cur_reg.srqFlag;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  priority_top_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.autoDisc |-> systemConditionByte[5:0] == 6'h05)
    else $error("autodisconnect code not shown");
  break_code_a: assert property (@(posedge core_clk) disable iff (rst)
    !cond.autoDisc && !cur_reg.keySeen && cur_reg.breakSeen
    |-> systemConditionByte[5:0] == 6'h0A)
    else $error("break code wrong");
  rx_code_a: assert property (@(posedge core_clk) disable iff (rst)
    activeVec[6:3] == 4'h0 && cond.rxNotEmpty
    |-> systemConditionByte == {1'b1, cur_reg.srqFlag, 6'h22})
    else $error("receive ready code wrong");
  sticky_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    answerDone && !cond.parityErr |=> !bufferLineErrorByte[7])
    else $error("parity flag not cleared after answer");
  parity_set_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.parityErr |=> bufferLineErrorByte[7])
    else $error("parity flag not set");
  no_cts_a: assert property (@(posedge core_clk) disable iff (rst)
    handshakeEventByte[7] == (!cond.rtsOut && cond.ctsIn))
    else $error("cts response bit wrong");
  sw_redef_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.swRedefine |=> !handshakeEventByte[1])
    else $error("software block not cleared");
  srq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    !requestEnableControl[`ENABLE_SRQ_BIT] |=> !serviceRequest)
    else $error("request without enable");
  srq_sent_a: assert property (@(posedge core_clk) disable iff (rst)
    sentByte1 |=> !serviceRequest)
    else $error("request flag kept after byte one");
  order_a: assert property (@(posedge core_clk) disable iff (rst)
    statusValid && byteAccept && cur_reg.index == 3'd2 |=> statusData == 8'h00
    && statusLast)
    else $error("fourth byte wrong");
  spare_a: assert property (@(posedge core_clk) disable iff (rst)
    spareStatusByte == 8'h00)
    else $error("spare byte not fixed");
  key_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.keyPress |=> handshakeEventByte[6])
    else $error("key press not recorded");
  all_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    bufferLineErrorByte[3:0] == {cond.rxFull, cond.rxNotEmpty, cond.txNotFull,
    cond.txEmpty})
    else $error("buffer bits not live");
  top_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    systemConditionByte[7])
    else $error("system byte top bit low");

  // ----------------------------------------------------------------
  // further checks on codes, sticky bits and the answer sequence
  // ----------------------------------------------------------------
  // lower priority codes only show when every higher level is idle; the request bit mirrors its flag and drops without cause
  key_code_a: assert property (@(posedge core_clk) disable iff (rst)
    !cond.autoDisc && cur_reg.keySeen |-> systemConditionByte[5:0] == 6'h09)
    else $error("key press code wrong");
  data_err_code_a: assert property (@(posedge core_clk) disable iff (rst)
    activeVec[6:4] == 3'h0 && |cur_reg.byte2Sticky |-> systemConditionByte[5:0] == 6'h03)
    else $error("data error code wrong");
  tx_ready_code_a: assert property (@(posedge core_clk) disable iff (rst)
    activeVec[6:2] == 5'h00 && cond.txNotFull |-> systemConditionByte[5:0] == 6'h21)
    else $error("transmit ready code wrong");
  tx_full_code_a: assert property (@(posedge core_clk) disable iff (rst)
    activeVec[6:1] == 6'h00 |-> systemConditionByte[5:0] == 6'h23)
    else $error("transmit full code wrong");
  srq_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    systemConditionByte[6] == serviceRequest)
    else $error("request bit differs from request flag");
  srq_cause_a: assert property (@(posedge core_clk) disable iff (rst)
    !trigger |=> !serviceRequest)
    else $error("request kept without cause");

  // sticky event bits: set by the pulse, the set wins over an answer clear, but a redefine wins over a software block
  frame_set_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.frameErr |=> bufferLineErrorByte[6])
    else $error("frame flag not set");
  overrun_set_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.overrun |=> bufferLineErrorByte[5])
    else $error("overrun flag not set");
  overflow_set_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.rxOverflow |=> bufferLineErrorByte[4])
    else $error("overflow flag not set");
  break_set_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.breakRx |=> handshakeEventByte[4])
    else $error("break not recorded");
  syntax_set_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.syntaxErr |=> handshakeEventByte[2])
    else $error("syntax error not recorded");
  sw_set_a: assert property (@(posedge core_clk) disable iff (rst)
    cond.swBlock && !cond.swRedefine |=> handshakeEventByte[1])
    else $error("software block not recorded");

  // clearing after a full answer, unless a new event lands in that cycle
  frame_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    answerDone && !cond.frameErr |=> !bufferLineErrorByte[6])
    else $error("frame flag not cleared after answer");
  key_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    answerDone && !cond.keyPress |=> !handshakeEventByte[6])
    else $error("key flag not cleared after answer");
  break_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    answerDone && !cond.breakRx |=> !handshakeEventByte[4])
    else $error("break flag not cleared after answer");
  syntax_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    answerDone && !cond.syntaxErr |=> !handshakeEventByte[2])
    else $error("syntax flag not cleared after answer");

  // level bits follow their inputs in the same cycle
  auto_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    handshakeEventByte[5] == cond.autoDisc)
    else $error("autodisconnect bit wrong");
  remote_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    handshakeEventByte[3] == cond.remoteMode)
    else $error("remote mode bit wrong");
  hw_block_a: assert property (@(posedge core_clk) disable iff (rst)
    handshakeEventByte[0] == cond.hwBlock)
    else $error("hardware block bit wrong");

  // answer sequence: a byte stands until taken, then the next follows
  first_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    cur_reg.state == IDLE && statusRequest |=> statusValid && statusData[7])
    else $error("first byte not offered");
  byte_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    statusValid && !byteAccept |=> statusValid && $stable(statusData))
    else $error("offered byte changed before acceptance");
  second_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    statusValid && byteAccept && cur_reg.index == 3'd0
    |=> statusData == $past(bufferLineErrorByte))
    else $error("second byte wrong");
  third_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    statusValid && byteAccept && cur_reg.index == 3'd1
    |=> statusData == $past(handshakeEventByte))
    else $error("third byte wrong");
  idle_after_a: assert property (@(posedge core_clk) disable iff (rst)
    answerDone |=> !statusValid)
    else $error("answer did not end after fourth byte");

  full_answer_c: cover property (@(posedge core_clk) disable iff (rst) answerDone);
  sticky_event_c: cover property (@(posedge core_clk) disable iff (rst)
    answerDone && |cur_reg.byte2Sticky);
  srq_raised_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(serviceRequest));
  srq_sent_c: cover property (@(posedge core_clk) disable iff (rst)
    sentByte1 && serviceRequest);
  stall_c: cover property (@(posedge core_clk) disable iff (rst)
    statusValid && !byteAccept);
endmodule

// >>> verilog/loop_status_map.svh
// constants for the loop serial status register bank
`ifndef LOOP_STATUS_MAP_SVH
`define LOOP_STATUS_MAP_SVH
`define CODE_NO_ROOM 8'h85
`define CODE_KEY_INPUT 8'h89
`define CODE_BREAK 8'h8A
`define CODE_DATA_ERR 8'h83
`define CODE_RX_READY 8'hA2
`define CODE_TX_READY 8'hA1
`define CODE_TX_FULL 8'hA3
`define SRQ_BIT 6
`define SPARE_VALUE 8'h00
`define BYTE_COUNT 3'd4
`define ENABLE_SRQ_BIT 3
`endif

// >>> verilog/loop_status_pkg.sv
// types for the loop serial status register bank
package loop_status_pkg;
  // live and pulsed conditions reported by the surrounding device
  typedef struct packed {
    logic parityErr;
    logic frameErr;
    logic overrun;
    logic rxOverflow;
    logic rxFull;
    logic rxNotEmpty;
    logic txNotFull;
    logic txEmpty;
    logic rtsOut;
    logic ctsIn;
    logic keyPress;
    logic autoDisc;
    logic breakRx;
    logic remoteMode;
    logic syntaxErr;
    logic swBlock;
    logic swRedefine;
    logic hwBlock;
  } cond_t;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SEND = 2'b01
  } xfer_state_t;

  typedef struct packed {
    xfer_state_t state;
    logic [2:0] index;
    logic [7:0] dataOut;
    logic dataValid;
    logic srqFlag;
    logic [7:0] prevCode;
    logic [3:0] byte2Sticky;
    logic keySeen;
    logic breakSeen;
    logic syntaxSeen;
    logic swBlockFlag;
  } state_t;
endpackage
